// ==== common/crf_pkg.sv ====
/*
  Shared constants for the card-side SPI response token framer: register
  map, control bit positions, status flag positions, token values, command
  indices and the framer state type.
  Assumes a 32-bit APB register bus and a host-driven SPI link (mode 0).
*/
`default_nettype none
package crf_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_OCR = 8'h08;
  localparam logic [7:0] ADDR_RDW = 8'h0C;
  localparam logic [7:0] ADDR_WP = 8'h10;
  localparam logic [7:0] ADDR_BLK = 8'h14;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] OCR_RST = 32'h00FF_8000;
  localparam logic [31:0] RDW_RST = 32'h0000_0000;
  localparam logic [31:0] WP_RST = 32'h0000_0000;
  localparam logic [11:0] BLKLEN_RST = 12'h200;
  localparam logic [11:0] BLKLEN_MAX = 12'h800;
  // control register bits
  localparam int C_IDLE = 0;
  localparam int C_RD_CROSS = 1;
  localparam int C_WR_CROSS = 2;
  localparam int C_RD_FAIL = 3;
  localparam int C_ECC = 4;
  localparam int C_CC = 5;
  localparam int C_ERR = 6;
  localparam int C_ERASE_PARAM = 7;
  // short status flag positions (bit 7 always zero)
  localparam int F_IDLE = 0;
  localparam int F_ERASE_RST = 1;
  localparam int F_ILLEGAL = 2;
  localparam int F_CRC = 3;
  localparam int F_ERASE_SEQ = 4;
  localparam int F_ADDR = 5;
  localparam int F_PARAM = 6;
  // token values
  localparam logic [7:0] TOK_IDLE = 8'hFF;
  localparam logic [7:0] TOK_START = 8'hFE;
  localparam logic [7:0] TOK_BUSY = 8'h00;
  localparam logic [7:0] DRESP_OK = 8'h05;
  localparam logic [7:0] DRESP_CRC = 8'h0B;
  localparam logic [15:0] CRC16_POLY = 16'h1021;
  localparam logic [6:0] CRC7_POLY = 7'h09;
  // command indices
  localparam logic [5:0] CMD_GO_IDLE = 6'h00;
  localparam logic [5:0] CMD_STATUS = 6'h0D;
  localparam logic [5:0] CMD_BLKLEN = 6'h10;
  localparam logic [5:0] CMD_READ = 6'h11;
  localparam logic [5:0] CMD_WRITE = 6'h18;
  localparam logic [5:0] CMD_WP_QUERY = 6'h1E;
  localparam logic [5:0] CMD_TAG_FIRST = 6'h20;
  localparam logic [5:0] CMD_TAG_LAST = 6'h25;
  localparam logic [5:0] CMD_ERASE = 6'h26;
  localparam logic [5:0] CMD_LOCK = 6'h2A;
  localparam logic [5:0] CMD_OCR = 6'h3A;
  localparam logic [5:0] CMD_CRC = 6'h3B;
  localparam logic [31:0] PHYS_BLK = 32'h0000_0200;

  typedef enum logic [5:0] {
    S_CMD = 6'b000001,
    S_RESP = 6'b000010,
    S_BUSY = 6'b000100,
    S_TOKEN = 6'b001000,
    S_WWAIT = 6'b010000,
    S_WDATA = 6'b100000
  } crf_state_t;
endpackage
`default_nettype wire

// ==== dv/crf_framer_asserts.sv ====
/*
  Port checker for crf_framer: APB answers and data-out timing.
  Assumes a mode 0 host whose sclk half period is at least 4 pclk.
*/
`default_nettype none
module crf_framer_asserts
  import crf_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic spi_miso,
  input wire logic spi_miso_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic [3:0] age_q, age_d;
  logic sclk_q, sclk_d, bad, acc;
  assign acc = psel && penable;
  assign bad = !(paddr inside {ADDR_CTRL, ADDR_STAT, ADDR_OCR, ADDR_RDW, ADDR_WP, ADDR_BLK});
  // cycles since the last falling sclk, saturating
  always_comb begin
    sclk_d = spi_sclk;
    age_d = age_q;
    if (sclk_q && !spi_sclk)
      age_d = 4'h0;
    else if (age_q != 4'hF)
      age_d = age_q + 4'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q <= 4'hF;
      sclk_q <= 1'b0;
    end else begin
      age_q <= age_d;
      sclk_q <= sclk_d;
    end
  end
  chk_miso_after_fall: assert property (
    $changed(spi_miso) && !spi_miso_oe_n && $stable(spi_miso_oe_n) |-> age_q <= 4'h6)
    else $error("data out moved away from a falling sclk");
  chk_miso_holds_high: assert property (
    $rose(spi_sclk) |-> ##2 $stable(spi_miso) [*2])
    else $error("data out moved while sclk high");
  chk_release_deselect: assert property (spi_cs_n [*4] |-> spi_miso_oe_n)
    else $error("data out driven while deselected");
  chk_drive_selected: assert property (!spi_cs_n [*4] |-> !spi_miso_oe_n)
    else $error("data out not driven while selected");
  chk_zero_wait: assert property (acc |-> pready)
    else $error("apb access not answered");
  chk_unmapped_err: assert property (
    acc && bad && !pwrite |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  chk_err_only_bad: assert property (!(acc && bad) |-> !pslverr)
    else $error("spurious apb error");
  chk_ocr_readback: assert property (
    acc && pwrite && paddr == ADDR_OCR ##2 psel && !penable && !pwrite && paddr == ADDR_OCR
    |=> prdata == $past(pwdata, 3))
    else $error("register read back differs from write");
  cover property (acc && pslverr);
  cover property ($fell(spi_cs_n));
  cover property (!spi_miso_oe_n && !spi_miso);
endmodule
bind crf_framer crf_framer_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
  .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n));
`default_nettype wire

// ==== dv/crf_framer_tb.sv ====
/*
  Self-checking bench for crf_framer: APB tasks and a host model.
  Assumes crf_pkg and crf_host are compiled first.
*/
`default_nettype none
module crf_framer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import crf_pkg::*;
  localparam logic [31:0] OV = 32'h1234_5678;
  localparam logic [31:0] RV = 32'hA55A_3CC3;
  logic pclk = 1'b0, presetn, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, d;
  logic pready, pslverr, sclk, cs_n, mosi, miso, oe_n, e;
  logic [7:0] b, r;
  logic [7:0] ra [5] = '{ADDR_CTRL, ADDR_OCR, ADDR_RDW, ADDR_WP, ADDR_BLK};
  logic [31:0] rv [5] = '{CTRL_RST, OCR_RST, RDW_RST, WP_RST, {20'h00000, BLKLEN_RST}};
  wire logic mw;
  int failures = 0, n_tests = 0;
  assign mw = oe_n ? 1'b1 : miso;
  always #2 pclk = ~pclk;
  crf_framer #(.CARD_BYTES(32'h0002_0000), .BUSY_BYTES(12'h001)) DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe_n(oe_n));
  crf_host host (.pclk(pclk), .miso(mw), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
  task automatic test_done();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] v, input logic [31:0] ex);
    n_tests++;
    if (v !== ex) begin
      failures++;
      $display("wrong value %s expected %h seen %h", s, ex, v);
    end
  endtask
  task automatic c8(input string s, input logic [7:0] v, input logic [7:0] ex);
    chk(s, {24'h000000, v}, {24'h000000, ex});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v = 32'h0);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [6:0] crc7(input logic [39:0] m);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 39; i >= 0; i--)
      c = {c[5:0], 1'b0} ^ ((c[6] ^ m[i]) ? CRC7_POLY : 7'h00);
    return c;
  endfunction
  function automatic logic [15:0] crc16(input logic [31:0] m);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 31; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? CRC16_POLY : 16'h0000);
    return c;
  endfunction
  task automatic rb(input string s, input logic [7:0] ex);
    host.xb(8'hFF, b);
    c8(s, b, ex);
  endtask
  task automatic poll();
    r = 8'hFF;
    for (int i = 0; i < 16 && r === 8'hFF; i++)
      host.xb(8'hFF, r);
  endtask
  task automatic cmd(input logic [5:0] ix, input logic [31:0] a, input logic [7:0] ex);
    logic [39:0] m;
    m = {2'b01, ix, a};
    host.sel(1'b1);
    for (int i = 4; i >= 0; i--)
      host.xb(m[i*8+:8], b);
    host.xb({crc7(m), 1'b1}, b);
    poll();
    c8("status", r, ex);
  endtask
  task automatic cx(input logic [5:0] ix, input logic [31:0] a, input logic [7:0] ex);
    cmd(ix, a, ex);
    host.sel(1'b0);
  endtask
  task automatic tok(input logic [31:0] v);
    logic [15:0] c;
    c = crc16(v);
    poll();
    c8("start", r, TOK_START);
    for (int i = 3; i >= 0; i--)
      rb("data", v[i*8+:8]);
    rb("crc hi", c[15:8]);
    rb("crc lo", c[7:0]);
    host.sel(1'b0);
  endtask
  task automatic wblk(input logic [5:0] ix, input logic [31:0] v, input logic bad);
    logic [15:0] c;
    c = crc16(v) ^ {15'h0000, bad};
    cmd(ix, 32'h0000_0000, 8'h00);
    host.xb(8'hFF, b);
    host.xb(TOK_START, b);
    for (int i = 3; i >= 0; i--)
      host.xb(v[i*8+:8], b);
    host.xb(c[15:8], b);
    host.xb(c[7:0], b);
    poll();
    c8("data resp", r, bad ? DRESP_CRC : DRESP_OK);
    if (!bad)
      rb("busy", TOK_BUSY);
    rb("ready", TOK_IDLE);
    host.sel(1'b0);
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    test_done();
  end
  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ra[i]) begin
      apb(1'b0, ra[i]);
      chk("reset value", d, rv[i]);
    end
    apb(1'b0, 8'h18);
    chk("unmapped", {31'h00000000, e}, 32'h0000_0001);
    apb(1'b1, ADDR_BLK, 32'h0000_0005);
    apb(1'b1, ADDR_OCR, OV);
    apb(1'b0, ADDR_OCR);
    chk("ocr", d, OV);
    cmd(CMD_OCR, 32'h0000_0000, 8'h01);
    for (int i = 3; i >= 0; i--)
      rb("ocr byte", OV[i*8+:8]);
    host.sel(1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    cx(6'h01, 32'h0000_0000, 8'h04);
    cx(CMD_CRC, 32'h0000_0001, 8'h00);
    apb(1'b0, ADDR_STAT);
    chk("crc on", {31'h00000000, d[0]}, 32'h0000_0001);
    cx(CMD_CRC, 32'hFFFF_FFFE, 8'h00);
    apb(1'b0, ADDR_STAT);
    chk("crc off", {31'h00000000, d[0]}, 32'h0000_0000);
    cx(CMD_BLKLEN, 32'h0000_0801, 8'h40);
    cx(CMD_BLKLEN, 32'h0000_0004, 8'h00);
    apb(1'b0, ADDR_BLK);
    chk("blklen", d, 32'h0000_0004);
    cx(CMD_READ, 32'h0000_0002, 8'h20);
    apb(1'b1, ADDR_RDW, RV);
    cmd(CMD_READ, 32'h0000_0000, 8'h00);
    tok(RV);
    cx(CMD_TAG_FIRST, 32'h0000_0000, 8'h00);
    cx(CMD_BLKLEN, 32'h0000_0004, 8'h02);
    apb(1'b1, ADDR_CTRL, 32'h0000_00F8);
    cmd(CMD_READ, 32'h0000_0000, 8'h00);
    poll();
    c8("error token", r, 8'h07);
    host.sel(1'b0);
    cmd(CMD_STATUS, 32'h0000_0000, 8'h00);
    rb("extended", 8'h5C);
    host.sel(1'b0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    cx(CMD_CRC, 32'h0000_0001, 8'h00);
    wblk(CMD_WRITE, RV, 1'b0);
    wblk(CMD_WRITE, RV, 1'b1);
    wblk(CMD_LOCK, 32'h0400_0000, 1'b0);
    cmd(CMD_STATUS, 32'h0000_0000, 8'h00);
    rb("locked", 8'h01);
    host.sel(1'b0);
    wblk(CMD_LOCK, 32'h0000_0000, 1'b0);
    apb(1'b0, ADDR_STAT);
    chk("unlocked", {31'h00000000, d[1]}, 32'h0000_0000);
    apb(1'b1, ADDR_WP, 32'hFFFF_8421);
    cmd(CMD_WP_QUERY, 32'h0000_0000, 8'h00);
    tok(32'h0000_8421);
    test_done();
  end
endmodule
`default_nettype wire

// ==== dv/crf_host.sv ====
/*
  Host SPI controller model, mode 0, sclk low between frames.
  Assumes calls start just after a pclk edge; half period is 4 pclk.
*/
`default_nettype none
module crf_host (
  input wire logic pclk,
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b1;
  end
  task automatic xb(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      mosi <= t[i];
      repeat (4) @(posedge pclk);
      sclk <= 1'b1;
      repeat (4) @(posedge pclk);
      r[i] = miso;
      sclk <= 1'b0;
    end
  endtask
  task automatic sel(input logic on);
    logic [7:0] j;
    if (!on)
      xb(8'hFF, j);
    repeat (8) @(posedge pclk);
    cs_n <= !on;
    repeat (8) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ==== rtl/crf_framer.sv ====
/*
  Card-side SPI response token framer with an APB register file.
  Assumes a host SPI controller in mode 0 (data sampled on rising sclk,
  changed on falling sclk) whose clock is much slower than pclk, and an
  APB master on pclk. Link pins are resynchronised into pclk.
*/
// Functional notes
// - command 58 answers status byte plus four operating-conditions bytes.
// - command 59 argument bit zero turns CRC checking on or off; short status.
// - command 42 data block uses current block length; status then busy.
// - block crossing physical boundary is misaligned unless crossing allowed.
// - protection query sends 32 protection bits then 16 CRC bits.
// - last sent protection bit belongs to first addressed group; code sends wp_q bit 0 there whatever the base group.
// - groups beyond card range report protection bit zero.
// - all tokens and data bytes are sent most significant bit first.
// - every command but status query gets a short status, top bit zero.
// - seven low status bits are active-high error or state flags.
// - erase reset flag when foreign command clears a pending erase.
// - address error on misaligned address; parameter error on out of range.
// - busy bytes are zero while busy; non-zero byte means ready.
// - status query returns short status then an extended status byte.
// - extended byte flags erase, protect, ECC, controller, general, lock.
// - one bit flags protected erase skip or failed lock operation.
// - locked bit set while card is locked, cleared when unlocked.
// - operating-conditions response is five bytes long.
// - each written block gets data response 010 accepted, 101 CRC error.
// - data token is start byte, block of data, then 16-bit CRC.
// - failed read sends one-byte error token with extended error bits.
`default_nettype none
module crf_framer #(
  parameter logic [31:0] CARD_BYTES = 32'h0400_0000,
  parameter int WPG_SHIFT = 13,
  parameter logic [11:0] BUSY_BYTES = 12'h004
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n
);
  import crf_pkg::*;

  localparam logic [31:0] NGRP = CARD_BYTES >> WPG_SHIFT;

  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      r = {r[14:0], 1'b0} ^ ((r[15] ^ b[i]) ? CRC16_POLY : 16'h0000);
    end
    return r;
  endfunction

  function automatic logic [6:0] crc7(input logic [39:0] m);
    logic [6:0] r;
    r = 7'h00;
    for (int i = 39; i >= 0; i--) begin
      r = {r[5:0], 1'b0} ^ ((r[6] ^ m[i]) ? CRC7_POLY : 7'h00);
    end
    return r;
  endfunction

  // link pin synchronisers; first stages feed only the second stages
  logic [2:0] sclk_q;
  logic [1:0] cs_q, mosi_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q <= 3'h0;
      cs_q <= 2'h3;
      mosi_q <= 2'h3;
    end else begin
      sclk_q <= {sclk_q[1:0], spi_sclk};
      cs_q <= {cs_q[0], spi_cs_n};
      mosi_q <= {mosi_q[0], spi_mosi};
    end
  end
  logic cs_n, rise, fall;
  assign cs_n = cs_q[1];
  assign rise = sclk_q[1] & ~sclk_q[2];
  assign fall = ~sclk_q[1] & sclk_q[2];

  // APB register file
  logic [31:0] ctrl_q, ctrl_d, ocr_q, ocr_d, rdw_q, rdw_d, wp_q, wp_d, prdata_d;
  logic [31:0] rd_mux;
  logic hit;
  logic [7:0] r1_view, ext_byte;
  logic [11:0] blklen_q;
  logic crc_en_q, locked_q;
  always_comb begin
    ctrl_d = ctrl_q;
    ocr_d = ocr_q;
    rdw_d = rdw_q;
    wp_d = wp_q;
    hit = 1'b1;
    unique case (paddr)
      ADDR_CTRL: rd_mux = ctrl_q;
      ADDR_STAT: rd_mux = {8'h00, ext_byte, r1_view, 6'h00, locked_q, crc_en_q};
      ADDR_OCR: rd_mux = ocr_q;
      ADDR_RDW: rd_mux = rdw_q;
      ADDR_WP: rd_mux = wp_q;
      ADDR_BLK: rd_mux = {20'h00000, blklen_q};
      default: begin
        rd_mux = 32'h0000_0000;
        hit = 1'b0;
      end
    endcase
    prdata_d = (psel & ~penable & ~pwrite) ? rd_mux : prdata;
    if (psel & penable & pwrite) begin
      unique case (paddr)
        ADDR_CTRL: ctrl_d = {24'h000000, pwdata[7:0]};
        ADDR_OCR: ocr_d = pwdata;
        ADDR_RDW: rdw_d = pwdata;
        ADDR_WP: wp_d = pwdata;
        default: ;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      ocr_q <= OCR_RST;
      rdw_q <= RDW_RST;
      wp_q <= WP_RST;
      prdata <= 32'h0000_0000;
    end else begin
      ctrl_q <= ctrl_d;
      ocr_q <= ocr_d;
      rdw_q <= rdw_d;
      wp_q <= wp_d;
      prdata <= prdata_d;
    end
  end
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // bit layer: shift in on rising sclk, shift out on falling sclk
  logic [2:0] bcnt_q, bcnt_d;
  logic [7:0] rx_q, rx_d, tx_q, tx_d, txn_q, rx_byte;
  logic byte_done;
  assign rx_byte = {rx_q[6:0], mosi_q[1]};
  assign byte_done = rise & ~cs_n & (bcnt_q == 3'h7);
  always_comb begin
    bcnt_d = bcnt_q;
    rx_d = rx_q;
    tx_d = tx_q;
    if (cs_n) begin
      bcnt_d = 3'h0;
      tx_d = TOK_IDLE;
    end else if (rise) begin
      bcnt_d = bcnt_q + 3'h1;
      rx_d = rx_byte;
    end else if (fall) begin
      tx_d = (bcnt_q == 3'h0) ? txn_q : {tx_q[6:0], 1'b1};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_q <= 3'h0;
      rx_q <= 8'h00;
      tx_q <= TOK_IDLE;
      spi_miso <= 1'b1;
      spi_miso_oe_n <= 1'b1;
    end else begin
      bcnt_q <= bcnt_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      spi_miso <= tx_d[7];
      spi_miso_oe_n <= cs_n;
    end
  end

  // protection payload mask, bit i is wp_q bit i, zeroed when group base+i is beyond the card
  logic [31:0] wpm, grp0;
  logic [47:0] cmdw;
  assign grp0 = cmdw[39:8] >> WPG_SHIFT;
  for (genvar i = 0; i < 32; i++) begin : g_wpm
    assign wpm[i] = wp_q[i] & ((grp0 + 32'(i)) < NGRP);
  end

  // framer state
  crf_state_t st_q, st_d, post_q, post_d;
  logic [11:0] cnt_q, cnt_d, blklen_d;
  logic [2:0] ccnt_q, ccnt_d, idx_q, idx_d, len_q, len_d;
  logic [39:0] cmd_q, cmd_d;
  logic [7:0] resp_q [6];
  logic [7:0] resp_d [6];
  logic [7:0] txn_d, hi_q, hi_d, dbyte, r1, errtok;
  logic [15:0] crc_q, crc_d;
  logic [31:0] word_q, word_d, arg, offs;
  logic [6:0] r1f_q, r1f_d, nf;
  logic [5:0] ci;
  logic [4:0] egrp_q, egrp_d;
  logic [1:0] bsel;
  logic crc_en_d, locked_d, skip_q, skip_d, wpv_q, wpv_d, pend_q, pend_d;
  logic wlock_q, wlock_d, ldat_q, ldat_d, legal, ok, is_tag, dok, mis;

  assign ext_byte = {1'b0, ctrl_q[C_ERASE_PARAM], wpv_q, ctrl_q[C_ECC], ctrl_q[C_CC],
                     ctrl_q[C_ERR], skip_q, locked_q};
  assign r1_view = {1'b0, r1f_q[6:1], ctrl_q[C_IDLE]};
  assign errtok = {5'h00, ctrl_q[C_ECC], ctrl_q[C_CC], ctrl_q[C_ERR]};
  assign cmdw = {cmd_q, rx_byte};
  assign ci = cmdw[45:40];
  assign arg = cmdw[39:8];
  assign offs = {23'h000000, arg[8:0]} + {20'h00000, blklen_q};
  // block length is never zero: zero is refused as a parameter error
  assign mis = (arg % {20'h00000, blklen_q}) != 32'h0000_0000;
  assign is_tag = (ci >= CMD_TAG_FIRST) && (ci <= CMD_TAG_LAST);
  assign bsel = 2'(cnt_q[1:0] - 2'h2);
  always_comb begin
    unique case (bsel)
      2'h0: dbyte = word_q[31:24];
      2'h1: dbyte = word_q[23:16];
      2'h2: dbyte = word_q[15:8];
      default: dbyte = word_q[7:0];
    endcase
  end

  always_comb begin
    st_d = st_q;
    post_d = post_q;
    cnt_d = cnt_q;
    ccnt_d = ccnt_q;
    idx_d = idx_q;
    len_d = len_q;
    cmd_d = cmd_q;
    resp_d = resp_q;
    txn_d = txn_q;
    hi_d = hi_q;
    crc_d = crc_q;
    word_d = word_q;
    r1f_d = r1f_q;
    egrp_d = egrp_q;
    blklen_d = blklen_q;
    crc_en_d = crc_en_q;
    locked_d = locked_q;
    skip_d = skip_q;
    wpv_d = wpv_q;
    pend_d = pend_q;
    wlock_d = wlock_q;
    ldat_d = ldat_q;
    nf = 7'h00;
    r1 = 8'h00;
    ok = 1'b0;
    dok = 1'b0;
    legal = ci inside {CMD_GO_IDLE, CMD_STATUS, CMD_BLKLEN, CMD_READ, CMD_WRITE,
                       CMD_WP_QUERY, CMD_ERASE, CMD_LOCK, CMD_OCR, CMD_CRC} || is_tag;
    if (cs_n) begin
      st_d = S_CMD;
      ccnt_d = 3'h0;
      txn_d = TOK_IDLE;
    end else if (byte_done) begin
      txn_d = TOK_IDLE;
      unique case (st_q)
        S_CMD: begin
          if (ccnt_q != 3'h0 || rx_byte[7:6] == 2'b01) begin
            cmd_d = cmdw[39:0];
            ccnt_d = ccnt_q + 3'h1;
          end
          if (ccnt_q == 3'h5) begin
            ccnt_d = 3'h0;
            cmd_d = cmd_q; // keep the index for the token that follows
            nf[F_ILLEGAL] = ~legal;
            nf[F_CRC] = crc_en_q & (crc7(cmdw[47:8]) != cmdw[7:1]);
            if (ci inside {CMD_READ, CMD_WRITE, CMD_WP_QUERY} || is_tag) begin
              nf[F_PARAM] = arg >= CARD_BYTES;
            end
            if (ci == CMD_READ) begin
              nf[F_ADDR] = mis | ((offs > PHYS_BLK) & ~ctrl_q[C_RD_CROSS]);
            end
            if (ci == CMD_WRITE) begin
              nf[F_ADDR] = mis | ((offs > PHYS_BLK) & ~ctrl_q[C_WR_CROSS]);
            end
            if (ci == CMD_BLKLEN) begin
              nf[F_PARAM] = (arg == 32'h0) || (arg > {20'h00000, BLKLEN_MAX});
            end
            ok = (nf == 7'h00);
            if (pend_q && !is_tag && ci != CMD_ERASE && ci != CMD_STATUS) begin
              nf[F_ERASE_RST] = 1'b1;
              pend_d = 1'b0;
            end
            if (ok && ci == CMD_ERASE && !pend_q) begin
              nf[F_ERASE_SEQ] = 1'b1;
              ok = 1'b0;
            end
            r1 = {1'b0, nf[6:1] | r1f_q[6:1], ctrl_q[C_IDLE]};
            r1f_d = 7'h00;
            resp_d[0] = r1;
            len_d = 3'h1;
            post_d = S_CMD;
            st_d = S_RESP;
            idx_d = 3'h0;
            if (ok) begin
              unique case (ci)
                CMD_STATUS: begin
                  r1f_d = r1f_q;
                  r1f_d[F_ERASE_RST] = nf[F_ERASE_RST] | r1f_q[F_ERASE_RST];
                  resp_d[0] = {1'b0, r1f_q[6:1], ctrl_q[C_IDLE]};
                  resp_d[1] = ext_byte;
                  len_d = 3'h2;
                  skip_d = 1'b0;
                  wpv_d = 1'b0;
                end
                CMD_OCR: begin
                  resp_d[1] = ocr_q[31:24];
                  resp_d[2] = ocr_q[23:16];
                  resp_d[3] = ocr_q[15:8];
                  resp_d[4] = ocr_q[7:0];
                  len_d = 3'h5;
                end
                CMD_CRC: crc_en_d = arg[0];
                CMD_BLKLEN: blklen_d = arg[11:0];
                CMD_READ: begin
                  if (ctrl_q[C_RD_FAIL]) begin
                    resp_d[1] = TOK_IDLE;
                    resp_d[2] = errtok;
                    len_d = 3'h3;
                  end else begin
                    post_d = S_TOKEN;
                    word_d = rdw_q;
                  end
                end
                CMD_WP_QUERY: begin
                  post_d = S_TOKEN;
                  word_d = wpm;
                end
                CMD_WRITE, CMD_LOCK: begin
                  if (ci == CMD_WRITE && wp_q[5'(arg >> WPG_SHIFT)]) begin
                    wpv_d = 1'b1;
                  end else begin
                    post_d = S_WWAIT;
                    wlock_d = (ci == CMD_LOCK);
                  end
                end
                CMD_ERASE: begin
                  pend_d = 1'b0;
                  skip_d = skip_q | wp_q[egrp_q];
                  post_d = S_BUSY;
                end
                default: begin
                  if (is_tag) begin
                    pend_d = 1'b1;
                    if (ci == CMD_TAG_FIRST) begin
                      egrp_d = 5'(arg >> WPG_SHIFT);
                    end
                  end
                end
              endcase
            end
          end
        end
        S_RESP: begin
          txn_d = resp_q[idx_q];
          idx_d = idx_q + 3'h1;
          if (idx_q == len_q - 3'h1) begin
            st_d = post_q;
            cnt_d = 12'h000;
            crc_d = 16'h0000;
          end
        end
        S_BUSY: begin
          if (cnt_q == BUSY_BYTES) begin
            st_d = S_CMD;
          end else begin
            txn_d = TOK_BUSY;
            cnt_d = cnt_q + 12'h001;
          end
        end
        S_TOKEN: begin
          cnt_d = cnt_q + 12'h001;
          if (cnt_q == 12'h001) begin
            txn_d = TOK_START;
          end else if (cnt_q != 12'h000) begin
            if (cnt_q - 12'h002 < tlen()) begin
              txn_d = dbyte;
              crc_d = crc16(crc_q, dbyte);
            end else if (cnt_q - 12'h002 == tlen()) begin
              txn_d = crc_q[15:8];
            end else begin
              txn_d = crc_q[7:0];
              st_d = S_CMD;
            end
          end
        end
        S_WWAIT: begin
          if (rx_byte == TOK_START) begin
            st_d = S_WDATA;
            cnt_d = 12'h000;
            crc_d = 16'h0000;
          end
        end
        S_WDATA: begin
          cnt_d = cnt_q + 12'h001;
          hi_d = rx_byte;
          if (cnt_q < blklen_q) begin
            crc_d = crc16(crc_q, rx_byte);
            if (cnt_q == 12'h000) begin
              ldat_d = rx_byte[2];
            end
          end else if (cnt_q == blklen_q + 12'h001) begin
            dok = ~crc_en_q | (crc_q == {hi_q, rx_byte});
            resp_d[0] = dok ? DRESP_OK : DRESP_CRC;
            len_d = 3'h1;
            idx_d = 3'h0;
            st_d = S_RESP;
            post_d = dok ? S_BUSY : S_CMD;
            if (wlock_q) begin
              if (dok) begin
                locked_d = ldat_q;
              end else begin
                skip_d = 1'b1;
              end
            end
          end
        end
        default: st_d = S_CMD;
      endcase
    end
  end

  // data length of the current token: a word of protection bits or a block
  function automatic logic [11:0] tlen();
    return (cmd_q[37:32] == CMD_WP_QUERY) ? 12'h004 : blklen_q;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_CMD;
      post_q <= S_CMD;
      cnt_q <= 12'h000;
      ccnt_q <= 3'h0;
      idx_q <= 3'h0;
      len_q <= 3'h1;
      cmd_q <= 40'h00_0000_0000;
      resp_q <= '{default: 8'hFF};
      txn_q <= TOK_IDLE;
      hi_q <= 8'h00;
      crc_q <= 16'h0000;
      word_q <= 32'h0000_0000;
      r1f_q <= 7'h00;
      egrp_q <= 5'h00;
      blklen_q <= BLKLEN_RST;
      crc_en_q <= 1'b0;
      locked_q <= 1'b0;
      skip_q <= 1'b0;
      wpv_q <= 1'b0;
      pend_q <= 1'b0;
      wlock_q <= 1'b0;
      ldat_q <= 1'b0;
    end else begin
      st_q <= st_d;
      post_q <= post_d;
      cnt_q <= cnt_d;
      ccnt_q <= ccnt_d;
      idx_q <= idx_d;
      len_q <= len_d;
      cmd_q <= cmd_d;
      resp_q <= resp_d;
      txn_q <= txn_d;
      hi_q <= hi_d;
      crc_q <= crc_d;
      word_q <= word_d;
      r1f_q <= r1f_d;
      egrp_q <= egrp_d;
      blklen_q <= blklen_d;
      crc_en_q <= crc_en_d;
      locked_q <= locked_d;
      skip_q <= skip_d;
      wpv_q <= wpv_d;
      pend_q <= pend_d;
      wlock_q <= wlock_d;
      ldat_q <= ldat_d;
    end
  end
endmodule
`default_nettype wire
